// ---- shared/aoa_defs.svh ----
// constants of the analog output alarm and status block
`ifndef AOA_DEFS_SVH
`define AOA_DEFS_SVH

`define AOA_CLK_HZ          50000000
`define AOA_FLASH_HALF_MS   250
`define AOA_MONITOR_MS      100
`define AOA_RESTART_CYCLES  16

// refreshed I/O area: base = 2000 + 10 * unit number
`define AOA_AREA_BASE       16'h07D0
`define AOA_AREA_STRIDE     16'h000A
`define AOA_AREA_WORDS      16'h000A
`define AOA_OFS_SELECT      16'h0000
`define AOA_OFS_CONTROL     16'h0001
`define AOA_OFS_STATUS      16'h0009
`define AOA_UNIT_MAX        7'h5F

// status word fields
`define AOA_BIT_RANGE_LO    0
`define AOA_BIT_CFG_ERR     10
`define AOA_BIT_OUTNUM_ERR  13
`define AOA_BIT_NV_FAIL     14
`define AOA_BIT_ADJ_MODE    15
`define AOA_STATUS_RESET    16'h0000

// control word: store trigger
`define AOA_BIT_STORE       4

// adjustment output numbers 11..14
`define AOA_ADJ_NUM_MIN     8'h0B
`define AOA_ADJ_NUM_MAX     8'h0E

// stopped-conversion behaviour codes 0000..0002
`define AOA_STOP_CODE_MAX   16'h0002

`define AOA_ZERO_CODE       16'h0000
`define AOA_RANGE_MIN       16'h0000
`define AOA_RANGE_MAX       16'h0FA0

`endif

// ---- shared/aoa_pkg.sv ----
// types of the analog output alarm and status block
package aoa_pkg;

   typedef enum logic [4:0]
   {
      ST_RESTART = 5'h01,
      ST_NORMAL  = 5'h02,
      ST_ADJUST  = 5'h04,
      ST_FROZEN  = 5'h08,
      ST_BADUNIT = 5'h10
   } aoa_state_type;

   typedef enum logic [1:0]
   {
      HM_PROGRAM = 2'h0,
      HM_MONITOR = 2'h1,
      HM_RUN     = 2'h2
   } aoa_hostmode_type;

endpackage : aoa_pkg

// ---- shared/aoa_pin_if.sv ----
// pin group between the top and its input synchroniser
`timescale 1ns/1ps
`default_nettype none

interface aoa_pin_if #(parameter int WIDTH = 8);
   logic [WIDTH-1:0] raw;
   logic [WIDTH-1:0] clean;
   modport sync (input raw, output clean);
   modport user (output raw, input clean);
endinterface : aoa_pin_if

`default_nettype wire

// ---- logic/aoa_pin_sync.sv ----
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none

module aoa_pin_sync
   import aoa_pkg::*;
#(
   parameter int WIDTH = 8
)
(
   input  wire logic  clk,    // system clock
   input  wire logic  rstn,   // async reset, active low
   aoa_pin_if.sync    pins    // raw pins in, filtered out
);

   logic [WIDTH-1:0] stage1;
   logic [WIDTH-1:0] stage2;
   logic [WIDTH-1:0] stage3;

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         stage1 <= '0;
         stage2 <= '0;
         stage3 <= '0;
      end
      else
      begin
         stage1 <= pins.raw;
         stage2 <= stage1;
         stage3 <= stage2;
      end
   end

   // a bit changes only once the last two stages agree
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         pins.clean <= '0;
      else
      begin
         for (int i = 0; i < WIDTH; i++)
            if (stage2[i] == stage3[i])
               pins.clean[i] <= stage3[i];
      end
   end

endmodule : aoa_pin_sync

`default_nettype wire

// ---- logic/aoa_alarm_status.sv ----
// alarm, indicator and status word logic of the analog output unit
`timescale 1ns/1ps
`default_nettype none
`include "aoa_defs.svh"

module aoa_alarm_status
   import aoa_pkg::*;
#(
   parameter int NUM_OUTPUTS    = 8,
   parameter int RESTART_CYCLES = `AOA_RESTART_CYCLES,
   parameter int FLASH_CYCLES   = (`AOA_CLK_HZ / 1000) * `AOA_FLASH_HALF_MS,
   parameter int MONITOR_CYCLES = (`AOA_CLK_HZ / 1000) * `AOA_MONITOR_MS
)
(
   input  wire logic                         clk,            // system clock
   input  wire logic                         rstn,           // async reset, active low
   input  wire logic [6:0]                   unitNumberPin,  // unit number switch, pin
   input  wire logic                         adjSwitchPin,   // adjustment mode switch, pin
   input  wire logic                         refreshRdEn,    // host refresh read strobe
   input  wire logic                         refreshWrEn,    // host refresh write strobe
   input  wire logic [15:0]                  refreshAddr,    // refreshed word address
   input  wire logic [15:0]                  refreshWrData,  // refreshed write data
   output logic [15:0]                       refreshRdData,  // refreshed read data
   output logic                              refreshRdValid, // read answer valid
   input  wire logic [1:0]                   hostMode,       // host program/monitor/run
   input  wire logic                         busFault,       // I/O bus error
   input  wire logic                         wdtFault,       // host watchdog timeout
   input  wire logic                         dupUnit,        // duplicate unit number seen
   input  wire logic                         restartBit,     // per-unit restart bit
   input  wire logic [15:0]                  stopBehaviour,  // setup stop behaviour code
   input  wire logic [NUM_OUTPUTS-1:0]       chanEnable,     // setup output-in-use mask
   input  wire logic [NUM_OUTPUTS-1:0][15:0] setValue,       // set values per output
   input  wire logic [NUM_OUTPUTS-1:0][15:0] holdValue,      // hold function values
   input  wire logic                         nvWriteFail,    // nonvolatile write failed
   output logic                              nvStore,        // start nonvolatile store
   output logic [NUM_OUTPUTS-1:0][15:0]      outValue,       // output codes to converters
   output logic                              runLed,         // operating indicator
   output logic                              unitFaultLed,   // unit error indicator
   output logic                              trimModeLed,    // adjusting indicator
   output logic                              hostFaultLed    // host error indicator
);

   // =======================================================
   // parameter checks
   // =======================================================
   if (NUM_OUTPUTS != 4 && NUM_OUTPUTS != 8)
   begin : g_bad_outputs
      $error("NUM_OUTPUTS must be 4 or 8");
   end
   if (RESTART_CYCLES < 4)
   begin : g_bad_restart
      $error("RESTART_CYCLES must cover the pin synchroniser");
   end
   if (FLASH_CYCLES < 1 || MONITOR_CYCLES < 2)
   begin : g_bad_counts
      $error("FLASH_CYCLES and MONITOR_CYCLES too small");
   end

   // =======================================================
   // functions
   // =======================================================
   function automatic logic [15:0] unitBase(input logic [6:0] unit);
      return `AOA_AREA_BASE + `AOA_AREA_STRIDE * {9'h000, unit};
   endfunction : unitBase

   function automatic logic adjNumberValid(input logic [7:0] num,
                                           input logic [NUM_OUTPUTS-1:0] used);
      logic [7:0] idx;
      idx = num - `AOA_ADJ_NUM_MIN;
      if (num < `AOA_ADJ_NUM_MIN || num > `AOA_ADJ_NUM_MAX)
         return 1'b0;
      return used[idx[1:0]];
   endfunction : adjNumberValid

   // =======================================================
   // pin synchroniser
   // =======================================================
   aoa_pin_if #(.WIDTH(8)) pinBus ();
   assign pinBus.raw = {adjSwitchPin, unitNumberPin};

   aoa_pin_sync #(.WIDTH(8)) u_pin_sync
   (
      .clk  (clk),
      .rstn (rstn),
      .pins (pinBus)
   );

   // =======================================================
   // state
   // =======================================================
   aoa_state_type        state;
   logic [6:0]           unitNumber;
   logic [15:0]          areaBase;
   logic [31:0]          restartCount;
   logic [31:0]          monitorCount;
   logic [31:0]          flashCount;
   logic                 flashPhase;
   logic                 restartPrev;
   logic                 restartFall;
   logic                 monitorLost;
   logic                 cfgErr;
   logic                 outNumErr;
   logic                 nvFail;
   logic [NUM_OUTPUTS-1:0] rangeErr;
   logic [7:0]           adjSelect;
   logic                 storePrev;
   logic                 storeRise;
   logic                 ownArea;
   logic                 hostConflict;
   logic                 unitBad;
   logic [15:0]          statusWord;

   assign restartFall  = restartPrev && !restartBit;
   assign areaBase     = unitBase(unitNumber);
   assign ownArea      = (refreshAddr >= areaBase) && (refreshAddr < areaBase + `AOA_AREA_WORDS);
   assign unitBad      = (pinBus.clean[6:0] > `AOA_UNIT_MAX) || dupUnit;
   assign hostConflict = (hostMode == HM_MONITOR) || (hostMode == HM_RUN);

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         restartPrev <= 1'b0;
      else
         restartPrev <= restartBit;
   end

   // restart count runs only in the restart state
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         restartCount <= '0;
      else if (restartFall || state != ST_RESTART)
         restartCount <= '0;
      else if (restartCount < RESTART_CYCLES - 1)
         restartCount <= restartCount + 32'h0000_0001;
   end

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         state <= ST_RESTART;
      else if (restartFall)
         state <= ST_RESTART;
      else
      begin
         unique case (state)
            ST_RESTART:
               if (restartCount == RESTART_CYCLES - 1)
               begin
                  if (unitBad)
                     state <= ST_BADUNIT;
                  else if (pinBus.clean[7])
                     state <= ST_ADJUST;
                  else
                     state <= ST_NORMAL;
               end
            ST_NORMAL:
               if (dupUnit)
                  state <= ST_BADUNIT;
            ST_ADJUST:
               if (dupUnit)
                  state <= ST_BADUNIT;
               else if (hostConflict)
                  state <= ST_FROZEN;
            ST_FROZEN:
               state <= ST_FROZEN;
            ST_BADUNIT:
               state <= ST_BADUNIT;
         endcase
      end
   end

   // unit number and setup checks are taken once, at the end of a restart
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         unitNumber <= 7'h00;
         cfgErr     <= 1'b0;
      end
      else if (state == ST_RESTART && restartCount == RESTART_CYCLES - 1)
      begin
         unitNumber <= pinBus.clean[6:0];
         cfgErr     <= (stopBehaviour > `AOA_STOP_CODE_MAX);
      end
   end

   // =======================================================
   // host refresh port
   // =======================================================
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         adjSelect <= 8'h00;
         storePrev <= 1'b0;
      end
      else if (state == ST_RESTART)
      begin
         adjSelect <= 8'h00;
         storePrev <= 1'b0;
      end
      else if (refreshWrEn && ownArea)
      begin
         if (refreshAddr == areaBase + `AOA_OFS_SELECT)
            adjSelect <= refreshWrData[7:0];
         if (refreshAddr == areaBase + `AOA_OFS_CONTROL)
            storePrev <= refreshWrData[`AOA_BIT_STORE];
      end
   end

   assign storeRise = refreshWrEn && ownArea && (refreshAddr == areaBase + `AOA_OFS_CONTROL)
                      && refreshWrData[`AOA_BIT_STORE] && !storePrev;

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         nvStore <= 1'b0;
      else
         nvStore <= storeRise && (state == ST_ADJUST) && !outNumErr;
   end

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         refreshRdData  <= 16'h0000;
         refreshRdValid <= 1'b0;
      end
      else
      begin
         refreshRdValid <= refreshRdEn && ownArea && (state != ST_BADUNIT);
         if (refreshRdEn && ownArea && refreshAddr == areaBase + `AOA_OFS_STATUS)
            refreshRdData <= statusWord;
         else
            refreshRdData <= 16'h0000;
      end
   end

   // silence from the host beyond the monitoring period
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         monitorCount <= '0;
      else if (state == ST_RESTART || ((refreshRdEn || refreshWrEn) && ownArea))
         monitorCount <= '0;
      else if (monitorCount < MONITOR_CYCLES)
         monitorCount <= monitorCount + 32'h0000_0001;
   end
   assign monitorLost = (monitorCount == MONITOR_CYCLES);

   // =======================================================
   // alarm flags
   // =======================================================
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         rangeErr <= '0;
      else
      begin
         for (int i = 0; i < NUM_OUTPUTS; i++)
            rangeErr[i] <= (state == ST_NORMAL) && chanEnable[i]
                           && (setValue[i] < `AOA_RANGE_MIN || setValue[i] > `AOA_RANGE_MAX);
      end
   end

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         outNumErr <= 1'b0;
      else
         outNumErr <= (state == ST_ADJUST) && !adjNumberValid(adjSelect, chanEnable);
   end

   // a failure in the same cycle as a retry trigger keeps the flag set
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         nvFail <= 1'b0;
      else if (state != ST_ADJUST)
         nvFail <= 1'b0;
      else if (nvWriteFail)
         nvFail <= 1'b1;
      else if (storeRise)
         nvFail <= 1'b0;
   end

   always_comb
   begin
      statusWord = `AOA_STATUS_RESET;
      if (state == ST_FROZEN)
         statusWord[`AOA_BIT_ADJ_MODE] = 1'b1;
      else
      begin
         statusWord[`AOA_BIT_RANGE_LO +: NUM_OUTPUTS] = rangeErr;
         statusWord[`AOA_BIT_CFG_ERR]    = cfgErr;
         statusWord[`AOA_BIT_OUTNUM_ERR] = outNumErr;
         statusWord[`AOA_BIT_NV_FAIL]    = nvFail;
         statusWord[`AOA_BIT_ADJ_MODE]   = (state == ST_ADJUST);
      end
   end

   // =======================================================
   // output selection
   // =======================================================
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         outValue <= '0;
      else
      begin
         for (int i = 0; i < NUM_OUTPUTS; i++)
         begin
            unique case (state)
               ST_RESTART, ST_BADUNIT:
                  outValue[i] <= `AOA_ZERO_CODE;
               ST_FROZEN:
                  outValue[i] <= outValue[i];
               ST_ADJUST:
                  if (outNumErr)
                     outValue[i] <= `AOA_ZERO_CODE;
                  else if (nvFail)
                     outValue[i] <= outValue[i];
                  else
                     outValue[i] <= setValue[i];
               ST_NORMAL:
                  if (cfgErr || !chanEnable[i])
                     outValue[i] <= `AOA_ZERO_CODE;
                  else if (monitorLost)
                     outValue[i] <= outValue[i];
                  else if (busFault || wdtFault)
                     outValue[i] <= holdValue[i];
                  else if (rangeErr[i])
                     outValue[i] <= holdValue[i];
                  else
                     outValue[i] <= setValue[i];
            endcase
         end
      end
   end

   // =======================================================
   // indicators
   // =======================================================
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         flashCount <= '0;
         flashPhase <= 1'b0;
      end
      else if (state != ST_ADJUST && state != ST_FROZEN)
      begin
         flashCount <= '0;
         flashPhase <= 1'b0;
      end
      else if (flashCount == FLASH_CYCLES - 1)
      begin
         flashCount <= '0;
         flashPhase <= !flashPhase;
      end
      else
         flashCount <= flashCount + 32'h0000_0001;
   end

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         runLed       <= 1'b0;
         unitFaultLed <= 1'b0;
         trimModeLed  <= 1'b0;
         hostFaultLed <= 1'b0;
      end
      else
      begin
         runLed       <= ((state == ST_NORMAL) && !cfgErr) || (state == ST_ADJUST);
         unitFaultLed <= (|statusWord[`AOA_BIT_NV_FAIL:0]) || (state == ST_FROZEN);
         trimModeLed  <= flashPhase;
         hostFaultLed <= (state == ST_BADUNIT)
                         || ((state != ST_RESTART) && (busFault || wdtFault || monitorLost));
      end
   end

endmodule : aoa_alarm_status

`default_nettype wire

// ---- bench/aoa_host_model.sv ----
// host controller model driving the refreshed I/O word bus
`timescale 1ns/1ps
`default_nettype none
`include "aoa_defs.svh"
module aoa_host_model
   import aoa_pkg::*;
#(
   parameter int UNIT = 3
)
(
   input  wire logic        clk,     // system clock
   input  wire logic [15:0] rdData,  // refreshed read data
   input  wire logic        rdValid, // read answer valid
   output logic             rdEn,    // read strobe
   output logic             wrEn,    // write strobe
   output logic [15:0]      addr,    // word address
   output logic [15:0]      wrData   // write data
);
   localparam logic [15:0] BASE = `AOA_AREA_BASE + `AOA_AREA_STRIDE * 16'(UNIT);

   initial
   begin
      {rdEn, wrEn} = 2'h0;
      {addr, wrData} = 32'h0;
   end

   // =========
   // bus cycles
   task automatic readWord(input logic [15:0] ofs, output logic [15:0] data, output logic ok);
      @(negedge clk);
      rdEn = 1'b1;
      addr = BASE + ofs;
      @(negedge clk);
      rdEn = 1'b0;
      addr = ~addr;
      data = rdData;
      ok = rdValid;
   endtask : readWord

   task automatic writeWord(input logic [15:0] ofs, input logic [15:0] data);
      @(negedge clk);
      wrEn = 1'b1;
      addr = BASE + ofs;
      wrData = data;
      @(negedge clk);
      wrEn = 1'b0;
      // released lines must not keep showing the last value
      addr = ~addr;
      wrData = ~wrData;
   endtask : writeWord

   task automatic retryStore();
      writeWord(`AOA_OFS_CONTROL, 16'h0000);
      writeWord(`AOA_OFS_CONTROL, 16'h0010);
      writeWord(`AOA_OFS_CONTROL, 16'h0000);
   endtask : retryStore
endmodule : aoa_host_model
`default_nettype wire

// ---- bench/aoa_alarm_status_asserts.sv ----
// port assertions of the alarm and status block
`timescale 1ns/1ps
`default_nettype none
`include "aoa_defs.svh"
module aoa_alarm_status_asserts
   import aoa_pkg::*;
#(
   parameter int NUM_OUTPUTS = 8
)
(
   input wire logic                         clk,            // clock
   input wire logic                         rstn,           // reset
   input wire logic                         refreshRdEn,    // read strobe
   input wire logic                         refreshWrEn,    // write strobe
   input wire logic [15:0]                  refreshWrData,  // write data
   input wire logic [15:0]                  refreshRdData,  // read data
   input wire logic                         refreshRdValid, // read valid
   input wire logic                         adjSwitchPin,   // mode switch
   input wire logic                         busFault,       // bus error
   input wire logic                         wdtFault,       // watchdog
   input wire logic                         dupUnit,        // duplicate unit
   input wire logic                         restartBit,     // restart
   input wire logic [NUM_OUTPUTS-1:0]       chanEnable,     // in-use mask
   input wire logic [NUM_OUTPUTS-1:0][15:0] holdValue,      // hold values
   input wire logic                         nvStore,        // store start
   input wire logic [NUM_OUTPUTS-1:0][15:0] outValue,       // outputs
   input wire logic                         runLed,         // run led
   input wire logic                         unitFaultLed,   // unit led
   input wire logic                         trimModeLed,    // trim led
   input wire logic                         hostFaultLed    // host led
);
   logic storeReq;
   assign storeReq = refreshWrEn && refreshWrData[`AOA_BIT_STORE];
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);

   // ==========
   // sequences
   sequence storeOnce;
      $past(storeReq) && nvStore ##1 !nvStore;
   endsequence

   // ==========
   // properties
   AST_RD_CAUSE: assert property (refreshRdValid |-> $past(refreshRdEn))
      else $error("read answer without a request");
   // mode is only sampled at restart end; bench moves the switch only in reset
   AST_ADJ_FLAG: assert property (refreshRdValid |-> refreshRdData[15] == adjSwitchPin)
      else $error("adjust flag disagrees with mode");
   AST_HI_ZERO: assert property (refreshRdValid && NUM_OUTPUTS == 4 |-> refreshRdData[7:4] == 4'h0)
      else $error("unused range flags set");
   AST_UNIT_LED: assert property (refreshRdValid && refreshRdData[13:0] != 14'h0000 |-> ##[0:1] unitFaultLed)
      else $error("unit fault led dark with alarm");
   AST_TRIM_OFF: assert property (refreshRdValid && !refreshRdData[15] |-> !trimModeLed)
      else $error("trim led lit outside adjust");
   AST_STORE: assert property (nvStore |-> storeOnce)
      else $error("store pulse without trigger or too long");
   AST_RESTART: assert property ($fell(restartBit) |-> ##4 (outValue == '0) [*8])
      else $error("outputs not zero in restart");
   AST_HOLD: assert property ((busFault || wdtFault) && runLed && &chanEnable |-> ##[1:3] outValue == holdValue)
      else $error("outputs not at hold value");
   AST_HOST_LED: assert property (busFault || wdtFault |-> ##[1:2] hostFaultLed)
      else $error("host fault led dark on fault");
   AST_BAD_UNIT: assert property (dupUnit |-> ##[1:3] (!runLed && hostFaultLed))
      else $error("bad unit leds wrong");
endmodule : aoa_alarm_status_asserts

bind aoa_alarm_status aoa_alarm_status_asserts #(.NUM_OUTPUTS(NUM_OUTPUTS)) chk (.clk(clk), .rstn(rstn),
   .refreshRdEn(refreshRdEn), .refreshWrEn(refreshWrEn), .refreshWrData(refreshWrData),
   .refreshRdData(refreshRdData), .refreshRdValid(refreshRdValid), .adjSwitchPin(adjSwitchPin),
   .busFault(busFault), .wdtFault(wdtFault), .dupUnit(dupUnit), .restartBit(restartBit),
   .chanEnable(chanEnable), .holdValue(holdValue), .nvStore(nvStore), .outValue(outValue), .runLed(runLed),
   .unitFaultLed(unitFaultLed), .trimModeLed(trimModeLed), .hostFaultLed(hostFaultLed));
`default_nettype wire

// ---- bench/aoa_alarm_status_tb.sv ----
// self-checking bench of the alarm and status block
`timescale 1ns/1ps
`default_nettype none
`include "aoa_defs.svh"
module aoa_alarm_status_tb
   import aoa_pkg::*;
;
   localparam int N = 4;
   logic clk = 1'b0;
   logic rstn, adjSwitchPin, busFault, wdtFault, dupUnit, restartBit, nvWriteFail, nvStore;
   logic refreshRdEn, refreshWrEn, refreshRdValid, runLed, unitFaultLed, trimModeLed, hostFaultLed;
   logic [15:0] refreshAddr, refreshWrData, refreshRdData, stopBehaviour;
   logic [1:0] hostMode;
   logic [N-1:0] chanEnable;
   logic [N-1:0][15:0] setValue, outValue, saved, expOut;
   logic [N-1:0][15:0] holdValue = {16'h0444, 16'h0333, 16'h0222, 16'h0111};
   logic [6:0] unitPin = 7'h03;
   logic [63:0] rowSet [5] = '{64'h0FA0_0000_0800_0123, 64'h0FA0_0000_0FA1_0123, 64'h1000_0000_0800_FFFF,
                               64'hFFFF_8000_7FFF_0FA1, 64'h0FA0_0000_0800_0123};
   logic [15:0] rowStat [5] = '{16'h0000, 16'h0002, 16'h0009, 16'h000F, 16'h0000};
   int failures = 0;
   int checked = 0;
   int cnt = 0;

   always #10 clk = ~clk;

   aoa_alarm_status #(.NUM_OUTPUTS(N), .FLASH_CYCLES(4), .MONITOR_CYCLES(20)) uut (.clk(clk), .rstn(rstn),
      .unitNumberPin(unitPin), .adjSwitchPin(adjSwitchPin), .refreshRdEn(refreshRdEn), .refreshWrEn(refreshWrEn),
      .refreshAddr(refreshAddr), .refreshWrData(refreshWrData), .refreshRdData(refreshRdData),
      .refreshRdValid(refreshRdValid), .hostMode(hostMode), .busFault(busFault), .wdtFault(wdtFault),
      .dupUnit(dupUnit), .restartBit(restartBit), .stopBehaviour(stopBehaviour), .chanEnable(chanEnable),
      .setValue(setValue), .holdValue(holdValue), .nvWriteFail(nvWriteFail), .nvStore(nvStore),
      .outValue(outValue), .runLed(runLed), .unitFaultLed(unitFaultLed), .trimModeLed(trimModeLed),
      .hostFaultLed(hostFaultLed));

   aoa_host_model #(.UNIT(3)) host (.clk(clk), .rdData(refreshRdData), .rdValid(refreshRdValid),
      .rdEn(refreshRdEn), .wrEn(refreshWrEn), .addr(refreshAddr), .wrData(refreshWrData));

   // ==========
   // helpers
   task automatic cmpVec(input logic [79:0] got, input logic [79:0] exp);
      checked++;
      if (got !== exp)
      begin
         failures++;
         $display("MISMATCH %0t got %h exp %h", $time, got, exp);
      end
   endtask : cmpVec

   task automatic ticks(input int n);
      repeat (n) @(negedge clk);
   endtask : ticks

   task automatic readStatus(input logic [15:0] exp);
      logic [15:0] d;
      logic ok;
      host.readWord(`AOA_OFS_STATUS, d, ok);
      cmpVec(ok, 1'b1);
      cmpVec(d, exp);
   endtask : readStatus

   task automatic doReset(input logic trim_mode_led);
      rstn = 1'b0;
      adjSwitchPin = trim_mode_led;
      ticks(6);
      rstn = 1'b1;
      ticks(4);
      cmpVec({runLed, outValue}, 80'h0);
      ticks(18);
   endtask : doReset

   task automatic restart();
      restartBit = 1'b1;
      ticks(2);
      restartBit = 1'b0;
      ticks(5);
      cmpVec(outValue, 80'h0);
      ticks(18);
   endtask : restart

   task automatic summarize();
      if (failures == 0 && checked > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : summarize

   // ==========
   // sequence
   initial
   begin
      {busFault, wdtFault, dupUnit, restartBit, nvWriteFail} = 5'h00;
      hostMode = HM_RUN;
      stopBehaviour = 16'h0000;
      chanEnable = 4'hF;
      setValue = rowSet[0];
      doReset(1'b0);
      for (int i = 0; i < 5; i++)
      begin
         setValue = rowSet[i];
         ticks(3);
         readStatus(rowStat[i]);
         for (int c = 0; c < N; c++)
            expOut[c] = rowStat[i][c] ? holdValue[c] : setValue[c];
         cmpVec(outValue, expOut);
         cmpVec({runLed, unitFaultLed}, {1'b1, |rowStat[i]});
      end
      for (int f = 0; f < 2; f++)
      begin
         {busFault, wdtFault} = f ? 2'b01 : 2'b10;
         ticks(3);
         cmpVec({hostFaultLed, outValue}, {1'b1, holdValue});
         {busFault, wdtFault} = 2'b00;
         ticks(3);
         cmpVec(hostFaultLed, 1'b0);
         readStatus(16'h0000);
      end
      saved = outValue;
      ticks(25);
      setValue = 64'h0001_0002_0003_0004;
      ticks(3);
      cmpVec({hostFaultLed, outValue}, {1'b1, saved});
      readStatus(16'h0000);
      ticks(3);
      cmpVec(hostFaultLed, 1'b0);
      for (int k = 0; k < 4; k++)
      begin
         stopBehaviour = 16'(k);
         restart();
         readStatus(k == 3 ? 16'h0400 : 16'h0000);
         cmpVec(runLed, k != 3);
      end
      stopBehaviour = 16'h0000;
      ticks(3);
      readStatus(16'h0400);
      restart();
      readStatus(16'h0000);
      dupUnit = 1'b1;
      ticks(4);
      cmpVec({runLed, hostFaultLed, outValue}, {2'b01, 64'h0});
      dupUnit = 1'b0;
      unitPin = 7'h60;
      restart();
      cmpVec({runLed, hostFaultLed, outValue}, {2'b01, 64'h0});
      unitPin = 7'h03;
      restart();
      hostMode = HM_PROGRAM;
      doReset(1'b1);
      host.writeWord(`AOA_OFS_SELECT, 16'h000B);
      ticks(2);
      readStatus(16'h8000);
      for (int t = 0; t < 12; t++)
      begin
         ticks(1);
         cnt += int'(trimModeLed);
      end
      cmpVec(cnt inside {[1:11]}, 1'b1);
      host.writeWord(`AOA_OFS_SELECT, 16'h000F);
      ticks(2);
      readStatus(16'hA000);
      cmpVec(outValue, 80'h0);
      chanEnable = 4'hD;
      host.writeWord(`AOA_OFS_SELECT, 16'h000C);
      ticks(2);
      readStatus(16'hA000);
      chanEnable = 4'hF;
      ticks(2);
      readStatus(16'h8000);
      host.writeWord(`AOA_OFS_CONTROL, 16'h0010);
      cmpVec(nvStore, 1'b1);
      host.writeWord(`AOA_OFS_CONTROL, 16'h0000);
      saved = outValue;
      nvWriteFail = 1'b1;
      ticks(1);
      nvWriteFail = 1'b0;
      setValue = rowSet[1];
      ticks(2);
      readStatus(16'hC000);
      cmpVec(outValue, saved);
      host.retryStore();
      readStatus(16'h8000);
      hostMode = HM_MONITOR;
      ticks(3);
      saved = outValue;
      setValue = rowSet[0];
      ticks(3);
      readStatus(16'h8000);
      cmpVec(outValue, saved);
      summarize();
   end

   initial
   begin
      #40000;
      failures++;
      summarize();
   end
endmodule : aoa_alarm_status_tb
`default_nettype wire
